// ---- hw/pcp_defines.svh ----
// constants for the peripheral host port and printer pin front end
// assumes a single 100 MHz clock and a synchronous register strobe port
`ifndef PCP_DEFINES_SVH
`define PCP_DEFINES_SVH

// =====================================================================
// clock and timing
`define PCP_CLK_NS 10
`define PCP_FAST_CYC_NS 100
`define PCP_FAST_CYC ((`PCP_FAST_CYC_NS + `PCP_CLK_NS - 1) / `PCP_CLK_NS)

// =====================================================================
// serial element register offsets
`define PCP_SER_TXD 3'h0
`define PCP_SER_DIV 3'h1
`define PCP_SER_MCR 3'h4
`define PCP_SER_LSR 3'h5
`define PCP_SER_MSR 3'h6

// serial element fields
`define PCP_MCR_DTR 0
`define PCP_MCR_RTS 1
`define PCP_MSR_CTS 4
`define PCP_LSR_BUSY 0
`define PCP_DIV_RST 8'h0f
`define PCP_FRAME_BITS 4'ha

// =====================================================================
// printer port register offsets
`define PCP_PP_DATA 3'h0
`define PCP_PP_STAT 3'h1
`define PCP_PP_CTRL 3'h2
`define PCP_PP_FADDR 3'h3
`define PCP_PP_FDATA 3'h4
`define PCP_PP_MUX 3'h7

// printer control fields
`define PCP_CTL_STB 0
`define PCP_CTL_AFD 1
`define PCP_CTL_INIT 2
`define PCP_CTL_PRINTER_SELECT_IN 3
`define PCP_CTL_DIR 5
`define PCP_CTL_FAST 6
`define PCP_MUX_COMPAT 0

// port select codes
`define PCP_SEL_S0 2'h0
`define PCP_SEL_S1 2'h1
`define PCP_SEL_PP 2'h2
`define PCP_SEL_NONE 2'h3

`endif

// ---- hw/pcp_pkg.sv ----
// types shared by the peripheral host port design
// assumes pcp_defines.svh for all numeric constants
package pcp_pkg;

    typedef struct packed {
        logic [1:0] mcr;
        logic [7:0] div;
        logic [9:0] shift;
        logic [3:0] bits_left;
        logic [7:0] baud_cnt;
        logic [7:0] last_tx;
    } pcp_ser_s;

    typedef enum logic [1:0] {
        PCP_FIDLE = 2'b00,
        PCP_FWRITE = 2'b01,
        PCP_FREAD = 2'b10
    } pcp_fast_e;

    typedef struct packed {
        pcp_ser_s [1:0] ser;
        logic [1:0] cts_s1;
        logic [1:0] cts_s2;
        logic [13:0] pin_s1;
        logic [13:0] pin_s2;
        logic rts0_s1;
        logic rts0_s2;
        logic low_volt;
        logic [7:0] pdata;
        logic [7:0] ctrl;
        logic mux_compat;
        pcp_fast_e fstate;
        logic faddr;
        logic [7:0] fcnt;
        logic [7:0] rd_data;
        logic rd_oe;
    } pcp_state_s;

endpackage : pcp_pkg

// ---- hw/pcp_host_pins.sv ----
// pin front end: host register port, two serial elements, printer port
// assumes host strobes are synchronous to mclk; printer and modem pins
// are asynchronous and pass two flip-flops first
`timescale 1ns/10ps
`default_nettype none
`include "pcp_defines.svh"

// Notes on behaviour
// - rts output follows modem control bit 1
// - rts0 pin sampled in reset selects thresholds
// - clear-to-send shown in modem status bit 4
// - data bit 0 goes first on serial line
// - three address bits pick register of port
// - write strobe stores data into addressed register
// - read strobe returns addressed register on data
// - selects 0,1,2 pick serial 0, 1, printer
// - data lines driven only while returning read data
// - reset idles serial activity until software resumes
// - reset forces interrupt multiplexer non-compatible mode
// - normal mode strobe latches printer data
// - fast mode strobe low write, high read
// - normal mode autofeed advances form paper
// - fast mode autofeed low during data cycle
// - initialize line starts printer initialization
// - normal mode select-in selects printer
// - fast mode select-in low during address cycle
// - printer data lines work both directions
// - direction enable low forces data lines out, except during a fast mode read cycle
// - reset forces serial outputs to marking
// - dtr output follows modem control bit 0
module pcp_host_pins
    import pcp_pkg::*;
(
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_data_in,
    output logic [7:0] host_data_out,
    output logic host_data_oe,
    input wire logic host_write_strobe,
    input wire logic host_read_strobe,
    input wire logic port_select_0,
    input wire logic port_select_1,
    input wire logic port_select_2,
    output logic [1:0] serial_data_output,
    output logic [1:0] dtr,
    output logic rts1,
    input wire logic rts0_in,
    output logic rts0_out,
    output logic rts0_oe,
    input wire logic [1:0] cts,
    output logic low_voltage_mode,
    output logic interrupt_multiplexer_compat,
    input wire logic direction_enable_input,
    input wire logic [7:0] printer_data_in,
    output logic [7:0] printer_data_out,
    output logic printer_data_oe,
    output logic printer_strobe_n,
    output logic printer_autofeed_n,
    output logic printer_init_n,
    output logic printer_select_in_n,
    input wire logic printer_ack_n,
    input wire logic printer_busy,
    input wire logic printer_paper_empty,
    input wire logic printer_selected,
    input wire logic printer_error_n
);

    // =================================================================
    // helpers
    function automatic logic [1:0] pcp_sel(input logic s0, input logic s1,
                                           input logic s2);
        if (s0)
        begin
            return `PCP_SEL_S0;
        end
        else if (s1)
        begin
            return `PCP_SEL_S1;
        end
        else if (s2)
        begin
            return `PCP_SEL_PP;
        end
        return `PCP_SEL_NONE;
    endfunction : pcp_sel

    function automatic pcp_ser_s pcp_ser_reset();
        pcp_ser_s s;
        s = '0;
        s.div = `PCP_DIV_RST;
        s.shift = '1;
        return s;
    endfunction : pcp_ser_reset

    // =================================================================
    // serial element helpers, shared by both elements
    function automatic pcp_ser_s pcp_ser_tick(input pcp_ser_s s);
        pcp_ser_s r;
        r = s;
        if (s.bits_left != 4'h0)
        begin
            if (s.baud_cnt == s.div)
            begin
                r.baud_cnt = 8'h00;
                r.shift = {1'b1, s.shift[9:1]};
                r.bits_left = s.bits_left - 4'h1;
            end
            else
            begin
                r.baud_cnt = s.baud_cnt + 8'h01;
            end
        end
        return r;
    endfunction : pcp_ser_tick

    function automatic pcp_ser_s pcp_ser_load(input pcp_ser_s s,
                                              input logic [7:0] d);
        pcp_ser_s r;
        r = s;
        r.last_tx = d;
        // start bit low, data lsb first, stop bit high
        r.shift = {1'b1, d, 1'b0};
        r.bits_left = `PCP_FRAME_BITS;
        r.baud_cnt = 8'h00;
        return r;
    endfunction : pcp_ser_load

    function automatic logic [7:0] pcp_ser_read(input pcp_ser_s s,
                                                input logic cts_bit,
                                                input logic [2:0] a);
        logic [7:0] d;
        d = 8'h00;
        unique case (a)
            `PCP_SER_TXD: d = s.last_tx;
            `PCP_SER_DIV: d = s.div;
            `PCP_SER_MCR: d = {6'h00, s.mcr};
            `PCP_SER_LSR: d = {7'h00, s.bits_left != 4'h0};
            `PCP_SER_MSR: d = 8'(cts_bit) << `PCP_MSR_CTS;
            default: d = 8'h00;
        endcase
        return d;
    endfunction : pcp_ser_read

    // =================================================================
    // fast printer cycle start, shared by reads and writes
    function automatic pcp_state_s pcp_fast_start(input pcp_state_s s,
                                                  input pcp_fast_e kind,
                                                  input logic [2:0] a);
        pcp_state_s r;
        r = s;
        // outside fast mode these offsets are plain data moves
        if (s.ctrl[`PCP_CTL_FAST])
        begin
            r.fstate = kind;
            r.faddr = (a == `PCP_PP_FADDR);
            // a new access restarts a running cycle rather than queueing
            r.fcnt = 8'(`PCP_FAST_CYC - 1);
        end
        return r;
    endfunction : pcp_fast_start

    // =================================================================
    // state
    pcp_state_s st_r;
    pcp_state_s st_nxt;
    logic [1:0] sel;
    logic [7:0] pd_pins;
    logic dir_en;

    assign sel = pcp_sel(port_select_0, port_select_1, port_select_2);
    assign pd_pins = st_r.pin_s2[7:0];
    assign dir_en = st_r.pin_s2[8];

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.cts_s1 = cts;
        st_nxt.cts_s2 = st_r.cts_s1;
        st_nxt.pin_s1 = {printer_selected, printer_ack_n, printer_busy,
                         printer_paper_empty,
                         printer_error_n, direction_enable_input,
                         printer_data_in};
        st_nxt.pin_s2 = st_r.pin_s1;
        st_nxt.rts0_s1 = rts0_in;
        st_nxt.rts0_s2 = st_r.rts0_s1;
        st_nxt.rd_oe = 1'b0;
        st_nxt.rd_data = 8'h00;

        // =============================================================
        // serial transmitters shift out lsb first at the divisor rate
        for (int i = 0; i < 2; i++)
        begin
            st_nxt.ser[i] = pcp_ser_tick(st_r.ser[i]);
        end

        // =============================================================
        // fast mode bus cycle timer
        if (st_r.fstate != PCP_FIDLE)
        begin
            if (st_r.fcnt == 8'h00)
            begin
                st_nxt.fstate = PCP_FIDLE;
            end
            else
            begin
                st_nxt.fcnt = st_r.fcnt - 8'h01;
            end
        end

        // =============================================================
        // register writes; no select means nothing changes
        if (host_write_strobe && sel != `PCP_SEL_NONE)
        begin
            if (sel == `PCP_SEL_PP)
            begin
                unique case (host_addr)
                    `PCP_PP_DATA: st_nxt.pdata = host_data_in;
                    `PCP_PP_CTRL: st_nxt.ctrl = host_data_in;
                    `PCP_PP_MUX:
                        st_nxt.mux_compat = host_data_in[`PCP_MUX_COMPAT];
                    `PCP_PP_FADDR, `PCP_PP_FDATA:
                    begin
                        st_nxt.pdata = host_data_in;
                        st_nxt = pcp_fast_start(st_nxt, PCP_FWRITE,
                                                host_addr);
                    end
                    default: ;
                endcase
            end
            else
            begin
                unique case (host_addr)
                    `PCP_SER_TXD:
                    begin
                        // a write while busy restarts the frame
                        st_nxt.ser[sel[0]] = pcp_ser_load(
                            st_r.ser[sel[0]], host_data_in);
                    end
                    `PCP_SER_DIV: st_nxt.ser[sel[0]].div = host_data_in;
                    `PCP_SER_MCR: st_nxt.ser[sel[0]].mcr = host_data_in[1:0];
                    default: ;
                endcase
            end
        end

        // =============================================================
        // register reads, returned the next cycle only
        if (host_read_strobe && sel != `PCP_SEL_NONE)
        begin
            st_nxt.rd_oe = 1'b1;
            if (sel == `PCP_SEL_PP)
            begin
                unique case (host_addr)
                    `PCP_PP_DATA:
                        st_nxt.rd_data = printer_data_oe ? st_r.pdata
                                                         : pd_pins;
                    `PCP_PP_STAT: st_nxt.rd_data = {st_r.pin_s2[12:9],
                                                    st_r.pin_s2[13],
                                                    3'h0};
                    `PCP_PP_CTRL: st_nxt.rd_data = st_r.ctrl;
                    `PCP_PP_MUX: st_nxt.rd_data = {7'h00, st_r.mux_compat};
                    `PCP_PP_FADDR, `PCP_PP_FDATA:
                    begin
                        // fast reads return the pins as they stand now
                        st_nxt.rd_data = pd_pins;
                        st_nxt = pcp_fast_start(st_nxt, PCP_FREAD,
                                                host_addr);
                    end
                    default: st_nxt.rd_data = 8'h00;
                endcase
            end
            else
            begin
                st_nxt.rd_data = pcp_ser_read(st_r.ser[sel[0]],
                                              st_r.cts_s2[sel[0]],
                                              host_addr);
            end
        end
    end

    // =================================================================
    // state register; synchronous reset keeps the strap pair running

    always_ff @(posedge mclk)
    begin
        if (!nrst)
        begin
            st_r <= '0;
            st_r.ser <= {pcp_ser_reset(), pcp_ser_reset()};
            st_r.ctrl <= 8'h00;
            // the strap keeps being sampled for the whole reset
            st_r.low_volt <= ~st_r.rts0_s2;
            st_r.rts0_s1 <= rts0_in;
            st_r.rts0_s2 <= st_r.rts0_s1;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // =================================================================
    // pin drive
    always_comb
    begin
        logic fast;
        logic fbusy;
        fast = st_r.ctrl[`PCP_CTL_FAST];
        fbusy = (st_r.fstate != PCP_FIDLE);
        host_data_out = st_r.rd_data;
        host_data_oe = st_r.rd_oe;
        for (int i = 0; i < 2; i++)
        begin
            serial_data_output[i] = st_r.ser[i].shift[0];
            dtr[i] = st_r.ser[i].mcr[`PCP_MCR_DTR];
        end
        rts1 = st_r.ser[1].mcr[`PCP_MCR_RTS];
        rts0_out = st_r.ser[0].mcr[`PCP_MCR_RTS];
        // pin released in reset so the strap can be read
        rts0_oe = nrst;
        low_voltage_mode = st_r.low_volt;
        interrupt_multiplexer_compat = st_r.mux_compat;
        printer_data_out = st_r.pdata;
        if (fast && fbusy)
        begin
            printer_data_oe = (st_r.fstate == PCP_FWRITE);
        end
        else
        begin
            printer_data_oe = !dir_en || !st_r.ctrl[`PCP_CTL_DIR];
        end
        printer_init_n = !st_r.ctrl[`PCP_CTL_INIT];
        if (fast)
        begin
            // idle reads as a read so the strobe rests high
            printer_strobe_n = (st_r.fstate != PCP_FWRITE);
            printer_autofeed_n = !(fbusy && !st_r.faddr);
            printer_select_in_n = !(fbusy && st_r.faddr);
        end
        else
        begin
            printer_strobe_n = !st_r.ctrl[`PCP_CTL_STB];
            printer_autofeed_n = !st_r.ctrl[`PCP_CTL_AFD];
            printer_select_in_n = !st_r.ctrl[`PCP_CTL_PRINTER_SELECT_IN];
        end
    end

endmodule : pcp_host_pins
`default_nettype wire

// ---- bench/pcp_host_pins_assertions.sv ----
// checker for the host port and printer pin front end
// assumes it is bound into pcp_host_pins and sees only its ports
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// checker
module pcp_chk (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic [2:0] host_addr,
    input wire logic [7:0] host_data_in,
    input wire logic host_data_oe,
    input wire logic host_write_strobe,
    input wire logic host_read_strobe,
    input wire logic port_select_0,
    input wire logic port_select_1,
    input wire logic port_select_2,
    input wire logic [1:0] serial_data_output,
    input wire logic [1:0] dtr,
    input wire logic rts0_out,
    input wire logic rts0_oe,
    input wire logic rts0_in,
    input wire logic low_voltage_mode,
    input wire logic interrupt_multiplexer_compat,
    input wire logic printer_data_oe,
    input wire logic printer_strobe_n,
    input wire logic printer_autofeed_n,
    input wire logic printer_init_n,
    input wire logic printer_select_in_n
);
    logic any_sel;
    logic rd_acc;
    logic pp_wr;
    logic fast_r;
    logic [1:0] mcr_in;
    logic [3:0] ctl_lo;
    assign any_sel = port_select_0 | port_select_1 | port_select_2;
    assign rd_acc = host_read_strobe & any_sel;
    assign pp_wr = host_write_strobe & port_select_2 & ~port_select_0
        & ~port_select_1;
    assign mcr_in = host_data_in[1:0];
    assign ctl_lo = host_data_in[3:0];
    // mirror of the fast mode bit, so line meanings can be told apart
    always_ff @(posedge mclk)
    begin
        if (!nrst)
            fast_r <= 1'b0;
        else if (pp_wr && host_addr == 3'h2)
            fast_r <= host_data_in[6];
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    read_answer_a: assert property (rd_acc |=> host_data_oe)
        else $error("read strobe not answered");
    bus_release_a: assert property (host_data_oe |-> $past(rd_acc))
        else $error("data lines driven without a read");
    no_select_a: assert property (host_read_strobe && !any_sel |=> !host_data_oe)
        else $error("unselected read drove the bus");
    reset_idle_a: assert property (disable iff (1'b0) !nrst |=>
        serial_data_output == 2'b11 && dtr == 2'b00
        && !interrupt_multiplexer_compat) else $error("reset state wrong");
    strap_sample_a: assert property (disable iff (1'b0)
        (!nrst && !rts0_oe && $stable(rts0_in))[*3] |=>
        low_voltage_mode == !$past(rts0_in)) else $error("strap not taken");
    frame_start_a: assert property (host_write_strobe && port_select_0
        && host_addr == 3'h0 |=> !serial_data_output[0])
        else $error("no start bit after transmit write");
    modem_ctl_a: assert property (host_write_strobe && port_select_0
        && host_addr == 3'h4 |=> {rts0_out, dtr[0]} == $past(mcr_in))
        else $error("modem lines do not follow control");
    fast_write_a: assert property (fast_r && pp_wr && host_addr == 3'h4
        |=> (!printer_strobe_n && !printer_autofeed_n && printer_select_in_n
        && printer_data_oe)[*8]) else $error("fast data write lines wrong");
    normal_lines_a: assert property (!fast_r && pp_wr && host_addr == 3'h2
        && !host_data_in[6] |=> {printer_select_in_n, printer_init_n,
        printer_autofeed_n, printer_strobe_n} == ~$past(ctl_lo))
        else $error("printer lines do not mirror control");
endmodule : pcp_chk
bind pcp_host_pins pcp_chk i_chk (.*);
`default_nettype wire

// ---- bench/pcp_far_side.sv ----
// printer and modem model facing the pin front end
// assumes the bench sets status, clear-to-send and strap levels
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// model
module pcp_far_side (
    input wire logic mclk,
    input wire logic [7:0] printer_data_out,
    input wire logic printer_data_oe,
    input wire logic printer_strobe_n,
    input wire logic rts0_out,
    input wire logic rts0_oe,
    input wire logic strap_low,
    input wire logic [4:0] stat_set,
    output logic [7:0] printer_data_in,
    output logic [7:0] latched,
    output logic rts0_in,
    output logic printer_ack_n,
    output logic printer_busy,
    output logic printer_paper_empty,
    output logic printer_error_n,
    output logic printer_selected
);
    logic [7:0] pat_r = 8'h00;
    logic stb_r = 1'b1;
    // released lines wander, so a stale byte can never be read back
    assign printer_data_in = printer_data_oe ? printer_data_out : pat_r;
    // internal pull-up wins unless the board straps the pin low
    assign rts0_in = rts0_oe ? rts0_out : ~strap_low;
    assign {printer_ack_n, printer_busy, printer_paper_empty,
        printer_error_n, printer_selected} = stat_set;
    always @(posedge mclk)
    begin
        pat_r <= pat_r + 8'h35;
        stb_r <= printer_strobe_n;
        if (stb_r && !printer_strobe_n)
            latched <= printer_data_out;
    end
endmodule : pcp_far_side
`default_nettype wire

// ---- bench/pcp_host_pins_tb.sv ----
// self-checking bench for the host port and printer pin front end
// assumes pcp_far_side on the far pins and the bound checker
`timescale 1ns/10ps
`default_nettype none
// =====================================================================
// bench
module peripheral_host_and_printer_pins_tb_top;
    logic mclk = 1'b0, nrst = 1'b0, strap_low = 1'b1;
    logic host_write_strobe = 1'b0, host_read_strobe = 1'b0;
    logic port_select_0 = 1'b0, port_select_1 = 1'b0, port_select_2 = 1'b0;
    logic direction_enable_input = 1'b0, rts1, rts0_in, rts0_out, rts0_oe;
    logic [2:0] host_addr = 3'h0;
    logic [7:0] host_data_in = 8'h00, host_data_out, printer_data_in;
    logic [7:0] printer_data_out, latched;
    logic [1:0] cts = 2'h0, serial_data_output, dtr;
    logic [4:0] stat_set = 5'h00;
    logic host_data_oe, low_voltage_mode, interrupt_multiplexer_compat;
    logic printer_data_oe, printer_strobe_n, printer_autofeed_n;
    logic printer_init_n, printer_select_in_n, printer_ack_n, printer_busy;
    logic printer_paper_empty, printer_selected, printer_error_n;
    int failures = 0, n_checks = 0, cyc = 0;
    pcp_host_pins i_dut (.*);
    pcp_far_side i_far (.*);
    always #5 mclk = ~mclk;
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic w, input logic [2:0] sl,
        input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk);
        host_write_strobe <= w;
        host_read_strobe <= !w;
        {port_select_2, port_select_1, port_select_0} <= sl;
        host_addr <= a;
        host_data_in <= d;
        @(posedge mclk);
        host_write_strobe <= 1'b0;
        host_read_strobe <= 1'b0;
        #1;
    endtask : acc
    task automatic reset_dut(input logic s, input int n);
        @(posedge mclk);
        nrst <= 1'b0;
        strap_low <= s;
        repeat (n) @(posedge mclk);
        nrst <= 1'b1;
        #1;
    endtask : reset_dut
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : wrap_up
    // a hang is cut well beyond the few hundred cycles the run needs
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            failures++;
            wrap_up();
        end
    end
    initial
    begin
        logic [1:0] m [2];
        logic [9:0] fr;
        logic [7:0] v;
        logic s;
        void'($urandom(78313));
        m = '{2'h0, 2'h0};
        reset_dut(1'b1, 2);
        chk({low_voltage_mode, interrupt_multiplexer_compat, serial_data_output, dtr, printer_strobe_n, printer_init_n}, 8'hb3);
        for (int k = 0; k < 8; k++)
        begin
            s = 1'($urandom);
            v = 8'($urandom);
            m[s] = v[1:0];
            acc(1'b1, s ? 3'b010 : 3'b001, 3'h4, v);
            acc(1'b1, 3'b000, 3'h4, ~v);
            chk({4'h0, rts1, rts0_out, dtr}, {4'h0, m[1][1], m[0][1], m[1][0], m[0][0]});
            @(posedge mclk);
            cts <= 2'($urandom);
            repeat (3) @(posedge mclk);
            acc(1'b0, s ? 3'b010 : 3'b001, 3'h6, 8'h00);
            chk(host_data_out, {3'h0, cts[s], 4'h0});
        end
        acc(1'b0, 3'b000, 3'h6, 8'h00);
        chk({7'h0, host_data_oe}, 8'h00);
        acc(1'b0, 3'b001, 3'h7, 8'h00);
        chk(host_data_out, 8'h00);
        $display("modem and register port test done");
        acc(1'b1, 3'b001, 3'h1, 8'h00);
        v = 8'($urandom);
        fr = {1'b1, v, 1'b0};
        acc(1'b1, 3'b001, 3'h0, v);
        for (int i = 0; i < 10; i++)
        begin
            chk({7'h0, serial_data_output[0]}, {7'h0, fr[i]});
            @(posedge mclk);
            #1;
        end
        acc(1'b0, 3'b001, 3'h5, 8'h00);
        chk(host_data_out, 8'h00);
        acc(1'b0, 3'b001, 3'h0, 8'h00);
        chk(host_data_out, v);
        $display("serial frame test done");
        v = 8'($urandom);
        acc(1'b1, 3'b100, 3'h0, v);
        chk(printer_data_out, v);
        for (int k = 0; k < 6; k++)
        begin
            fr[7:0] = {3'h0, 5'($urandom)};
            acc(1'b1, 3'b100, 3'h2, fr[7:0]);
            chk({3'h0, printer_data_oe, printer_select_in_n, printer_init_n, printer_autofeed_n, printer_strobe_n}, {4'h1, ~fr[3:0]});
        end
        acc(1'b1, 3'b100, 3'h2, 8'h00);
        acc(1'b1, 3'b100, 3'h2, 8'h01);
        @(posedge mclk);
        #1;
        chk(latched, v);
        @(posedge mclk);
        stat_set <= 5'($urandom);
        repeat (3) @(posedge mclk);
        acc(1'b0, 3'b100, 3'h1, 8'h00);
        chk(host_data_out, {stat_set, 3'h0});
        acc(1'b1, 3'b100, 3'h2, 8'h20);
        for (int k = 1; k >= 0; k--)
        begin
            @(posedge mclk);
            direction_enable_input <= k[0];
            repeat (4) @(posedge mclk);
            #1;
            chk({7'h0, printer_data_oe}, {7'h0, ~k[0]});
        end
        $display("printer normal mode test done");
        acc(1'b1, 3'b100, 3'h2, 8'h40);
        for (int k = 0; k < 4; k++)
        begin
            acc(!k[1], 3'b100, k[0] ? 3'h3 : 3'h4, 8'h55);
            chk({4'h0, printer_strobe_n, printer_autofeed_n, printer_select_in_n, printer_data_oe}, {4'h0, k[1], k[0], ~k[0], ~k[1]});
            repeat (10) @(posedge mclk);
            #1;
            chk({4'h0, printer_strobe_n, printer_autofeed_n, printer_select_in_n, printer_data_oe}, 8'h0f);
        end
        acc(1'b1, 3'b100, 3'h2, 8'h00);
        $display("printer fast mode test done");
        acc(1'b1, 3'b100, 3'h7, 8'h01);
        chk({7'h0, interrupt_multiplexer_compat}, 8'h01);
        acc(1'b1, 3'b001, 3'h0, 8'h00);
        reset_dut(1'b0, 5);
        for (int i = 0; i < 12; i++)
        begin
            chk({low_voltage_mode, interrupt_multiplexer_compat, serial_data_output, dtr, printer_strobe_n, printer_init_n}, 8'h33);
            @(posedge mclk);
            #1;
        end
        $display("reset test done");
        wrap_up();
    end
endmodule : peripheral_host_and_printer_pins_tb_top
`default_nettype wire
